/* File: verif/rts_far_model.sv */
// far side: free-running rc timer clock, crystal clock, master clear pin
// assumes clk_sys at 100 MHz; both clocks are divided from it
module rts_far_model #(
  parameter int RC_HALF  = 10,
  parameter int OSC_HALF = 4
) (
  // clock
  input  wire logic clk_sys,
  // pin control
  input  wire logic master_clear_n_hold_low,
  input  wire logic master_clear_oe,
  // generated lines
  output logic      rc_timer_clk,
  output logic      oscillator_input,
  output logic      master_clear_n
);
  int rc_cnt  = 0;
  int osc_cnt = 0;

  // pulled up; low only while something pulls it down
  assign master_clear_n = !(master_clear_n_hold_low || master_clear_oe);
  assign rc_timer_clk = (rc_cnt >= RC_HALF);
  assign oscillator_input = (osc_cnt >= OSC_HALF);

  // both oscillators run free, as real ones do
  always @(posedge clk_sys)
  begin
    rc_cnt  <= (rc_cnt == 2 * RC_HALF - 1) ? 0 : rc_cnt + 1;
    osc_cnt <= (osc_cnt == 2 * OSC_HALF - 1) ? 0 : osc_cnt + 1;
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the reset and time-out sequencer
// assumes rts_far_model and the design are compiled first
`include "rts_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POWER_UP_TIMER = 4;
  localparam int OSCILLATOR_STARTUP_TIMER  = 4;
  localparam int RCP  = 20;
  localparam int OSCP = 8;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  rts_pkg::rts_bus_t bus = '0;
  logic [7:0]        rdata;
  logic              supply_rise = 1'b0;
  logic              brown_out_detect = 1'b0;
  logic              watchdog_timeout = 1'b0;
  logic              sleep_wake = 1'b0;
  logic              in_sleep = 1'b0;
  logic              master_clear_n_hold = 1'b0;
  logic              master_clear_n;
  logic              rc_timer_clk;
  logic              oscillator_input;
  logic              core_reset;
  logic              clock_out_pin;
  logic              master_clear_oe;
  logic              keep_reg_wipe;
  int                fail_count = 0;
  int                n_compared = 0;
  int                wipes = 0;
  int                n;
  int                k;
  int                co;
  logic [7:0]        w;

  always #5 clk_sys = ~clk_sys;
  // counts wipe pulses of unaffected registers
  always @(posedge clk_sys)
    if (keep_reg_wipe === 1'b1)
      wipes++;

  rts_sequencer #(.POWER_UP_TIMER_COUNT(POWER_UP_TIMER), .OST_COUNT(OSCILLATOR_STARTUP_TIMER)) rts_sequencer_inst (
    .clk_sys, .rst_n, .bus, .rdata, .master_clear_n, .supply_rise,
    .brown_out_detect, .watchdog_timeout, .rc_timer_clk, .oscillator_input,
    .sleep_wake, .in_sleep, .core_reset, .clock_out_pin, .master_clear_oe,
    .keep_reg_wipe);
  rts_far_model #(.RC_HALF(RCP / 2), .OSC_HALF(OSCP / 2)) rts_far_model_inst (
    .clk_sys, .master_clear_n_hold_low(master_clear_n_hold), .master_clear_oe, .rc_timer_clk,
    .oscillator_input, .master_clear_n);

  task automatic check(string what, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(logic [3:0] a, logic [7:0] m, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 d = rdata & m;
  endtask

  // waits for reset to be raised, bounded
  task automatic wait_rst();
    k = 0;
    while (core_reset !== 1'b1 && k < 20)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (core_reset !== 1'b1)
    begin
      fail_count++;
      finish_test();
    end
  endtask

  // cycles until reset is released, bounded
  task automatic hold_len();
    n = 0;
    while (core_reset !== 1'b0)
    begin
      @(posedge clk_sys);
      n++;
      if (n > 3000)
      begin
        fail_count++;
        finish_test();
      end
    end
  endtask

  task automatic por();
    supply_rise <= 1'b0;
    repeat (5) @(posedge clk_sys);
    supply_rise <= 1'b1;
    wait_rst();
    hold_len();
  endtask

  // expected {power-down, timeout} pattern per cause
  function automatic logic [7:0] exp_stat(rts_pkg::rts_cause_t c);
    case (c)
      rts_pkg::RTS_CAUSE_POR:        return 8'h03;
      rts_pkg::RTS_CAUSE_WDT:        return 8'h02;
      rts_pkg::RTS_CAUSE_MASTER_CLEAR_N_SLEEP: return 8'h01;
      default:                       return 8'h00;
    endcase
  endfunction

  task automatic cause_is(rts_pkg::rts_cause_t c, logic [7:0] st);
    reg_rd(`RTS_ADDR_CAUSE, 8'h07, w);
    check("cause", w, 8'(c));
    reg_rd(`RTS_ADDR_STAT, 8'h07, w);
    check("status", w, st);
  endtask

  initial
  begin
    void'($urandom(26));
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_rd(`RTS_ADDR_CFG, 8'hff, w);
    check("cfg", w, `RTS_CFG_RESET);
    reg_rd(4'h9, 8'hff, w);
    check("unmapped", w, 8'h00);
    wipes = 0;
    por();
    check("power_up_timer", n >= (POWER_UP_TIMER - 1) * RCP, 1'b1);
    check("wipe", wipes, 1);
    cause_is(rts_pkg::RTS_CAUSE_POR, exp_stat(rts_pkg::RTS_CAUSE_POR));
    reg_rd(`RTS_ADDR_PCS, 8'h02, w);
    check("pcs_por", w, 8'h00);
    // software sets the flags; random values first
    repeat (4)
    begin
      w = 8'($urandom) & 8'h03;
      reg_wr(`RTS_ADDR_PCS, w);
      reg_rd(`RTS_ADDR_PCS, 8'h03, co[7:0]);
      check("pcs", co[7:0], w);
    end
    reg_wr(`RTS_ADDR_PCS, 8'h03);
    // short random glitches on master clear are dropped
    repeat (4)
    begin
      master_clear_n_hold <= 1'b1;
      repeat (1 + $urandom % 2) @(posedge clk_sys);
      master_clear_n_hold <= 1'b0;
      repeat (12) @(posedge clk_sys);
      check("glitch", core_reset, 1'b0);
    end
    master_clear_n_hold <= 1'b1;
    repeat (200) @(posedge clk_sys);
    check("master_clear_n_held", core_reset, 1'b1);
    master_clear_n_hold <= 1'b0;
    hold_len();
    check("master_clear_n_fast", n <= 20, 1'b1);
    cause_is(rts_pkg::RTS_CAUSE_MASTER_CLEAR_N_RUN, 8'h03);
    reg_rd(`RTS_ADDR_PCS, 8'h03, w);
    check("pcs_kept", w, 8'h03);
    check("wipe_kept", wipes, 1);
    watchdog_timeout <= 1'b1;
    wait_rst();
    watchdog_timeout <= 1'b0;
    hold_len();
    cause_is(rts_pkg::RTS_CAUSE_WDT, exp_stat(rts_pkg::RTS_CAUSE_WDT));
    in_sleep <= 1'b1;
    master_clear_n_hold <= 1'b1;
    repeat (30) @(posedge clk_sys);
    master_clear_n_hold <= 1'b0;
    hold_len();
    in_sleep <= 1'b0;
    cause_is(rts_pkg::RTS_CAUSE_MASTER_CLEAR_N_SLEEP, 8'h01);
    // brown-out disabled: no reset
    brown_out_detect <= 1'b1;
    repeat (30) @(posedge clk_sys);
    check("bor_off", core_reset, 1'b0);
    brown_out_detect <= 1'b0;
    reg_wr(`RTS_ADDR_CFG, 8'h0f);
    brown_out_detect <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check("bor_held", core_reset, 1'b1);
    brown_out_detect <= 1'b0;
    repeat (20) @(posedge clk_sys);
    brown_out_detect <= 1'b1;
    repeat (10) @(posedge clk_sys);
    brown_out_detect <= 1'b0;
    hold_len();
    check("bor_power_up_timer", n >= (POWER_UP_TIMER - 1) * RCP, 1'b1);
    reg_rd(`RTS_ADDR_CAUSE, 8'h07, w);
    check("cause", w, 8'(rts_pkg::RTS_CAUSE_BOR));
    reg_rd(`RTS_ADDR_PCS, 8'h01, w);
    check("pcs_bor", w, 8'h00);
    check("master_clear_n_oe", master_clear_oe, 1'b0);
    // rc mode clock out: osc over four across 64 osc edges, bounded
    reg_wr(`RTS_ADDR_CFG, 8'h03);
    co = 0;
    k = 0;
    n = 0;
    while (k < 64 && n < 2000)
    begin
      w[1:0] = {oscillator_input, clock_out_pin};
      @(posedge clk_sys);
      n++;
      k += int'(oscillator_input && !w[1]);
      co += int'(clock_out_pin && !w[0]);
    end
    check("osc_edges", k, 64);
    check("clkout", co >= 15 && co <= 17, 1'b1);
    reg_wr(`RTS_ADDR_CFG, 8'h05);
    repeat (20) @(posedge clk_sys);
    check("clkout_xt", clock_out_pin, 1'b0);
    // wake from sleep in high-speed crystal mode runs the start-up count
    reg_wr(`RTS_ADDR_CFG, 8'h06);
    in_sleep <= 1'b1;
    sleep_wake <= 1'b1;
    wait_rst();
    sleep_wake <= 1'b0;
    hold_len();
    in_sleep <= 1'b0;
    check("wake_ost", n >= (OSCILLATOR_STARTUP_TIMER - 1) * OSCP, 1'b1);
    reg_wr(`RTS_ADDR_CFG, 8'h05);
    por();
    check("ost", n >= (OSCILLATOR_STARTUP_TIMER - 1) * OSCP, 1'b1);
    reg_wr(`RTS_ADDR_CFG, 8'h07);
    por();
    check("rc_skip", n <= 20, 1'b1);
    finish_test();
  end
endmodule

/* File: verilog/rts_consts.svh */
// constants for the reset and time-out sequencer
// assumes inclusion by bare name from design files
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH
// register map (offsets chosen locally)
`define RTS_ADDR_PCS      4'h0
`define RTS_ADDR_CFG      4'h1
`define RTS_ADDR_STAT     4'h2
`define RTS_ADDR_CAUSE    4'h3
// power control/status field positions
`define RTS_PCS_BOR_BIT   0
`define RTS_PCS_POR_BIT   1
// configuration field positions
`define RTS_CFG_OSC_LSB   0
`define RTS_CFG_POWER_UP_TIMER_BIT  2
`define RTS_CFG_BOREN_BIT 3
// status field positions
`define RTS_ST_TO_BIT     0
`define RTS_ST_PD_BIT     1
`define RTS_ST_RST_BIT    2
// configuration reset value: rc mode, delay enabled, brown-out off
`define RTS_CFG_RESET     8'h03
// timing
`define RTS_POWER_UP_TIMER_MS       72
`define RTS_RC_HZ         100000
`define RTS_OST_CYCLES    1024
`define RTS_FILT_CYCLES   4
`define RTS_CLKDIV        4
`endif

/* File: verilog/rts_pkg.sv */
// types for the reset and time-out sequencer
// assumes rts_consts.svh holds the numbers
package rts_pkg;
  typedef enum logic [1:0] {
    RTS_OSC_LP,
    RTS_OSC_XT,
    RTS_OSC_HS,
    RTS_OSC_RC
  } rts_osc_t;

  typedef enum logic [2:0] {
    RTS_CAUSE_NONE,
    RTS_CAUSE_POR,
    RTS_CAUSE_MASTER_CLEAR_N_RUN,
    RTS_CAUSE_MASTER_CLEAR_N_SLEEP,
    RTS_CAUSE_WDT,
    RTS_CAUSE_BOR
  } rts_cause_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rts_bus_t;
endpackage

/* File: verilog/rts_sequencer.sv */
// reset merge, power-up timer and oscillator start-up timer
// assumes all pins asynchronous to clk_sys; timer clocks sampled
//
// Chosen here: the address-and-strobe port and the register addresses.
`include "rts_consts.svh"
module rts_sequencer #(
  parameter int POWER_UP_TIMER_COUNT = `RTS_POWER_UP_TIMER_MS * (`RTS_RC_HZ / 1000),
  parameter int OST_COUNT  = `RTS_OST_CYCLES,
  parameter int FILT_LEN   = `RTS_FILT_CYCLES
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // register port
  input  wire rts_pkg::rts_bus_t bus,
  output logic [7:0]             rdata,
  // pins and detectors
  input  wire logic              master_clear_n,
  input  wire logic              supply_rise,
  input  wire logic              brown_out_detect,
  input  wire logic              watchdog_timeout,
  input  wire logic              rc_timer_clk,
  input  wire logic              oscillator_input,
  input  wire logic              sleep_wake,
  input  wire logic              in_sleep,
  // outputs
  output logic                   core_reset,
  output logic                   clock_out_pin,
  output logic                   master_clear_oe,
  output logic                   keep_reg_wipe
);
  localparam int PW = $clog2(POWER_UP_TIMER_COUNT + 1);
  localparam int OW = $clog2(OST_COUNT + 1);
  localparam int FW = $clog2(FILT_LEN + 1);

  // elaboration check: every counter needs at least one step
  if (POWER_UP_TIMER_COUNT < 1 || OST_COUNT < 1 || FILT_LEN < 1)
  begin : g_bad_counts
    $error("rts_sequencer: counts must be positive");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BROWN,
    ST_POWER_UP_TIMER,
    ST_OST,
    ST_HOLD
  } rts_state_t;

  // two-stage synchronisers for all asynchronous inputs
  // a third stage only serves edge detection, never a level
  logic [7:0] s1_q, s2_q, s3_q;
  wire  [7:0] raw = {in_sleep, sleep_wake, oscillator_input,
                     rc_timer_clk, watchdog_timeout, brown_out_detect,
                     supply_rise, master_clear_n};
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 8'h01;
      s2_q <= 8'h01;
      s3_q <= 8'h01;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire master_clear_n_s   = s2_q[0];
  wire rise_s   = s2_q[1];
  wire bod_s    = s2_q[2];
  wire wdt_s    = s2_q[3];
  wire rcclk_e  = s2_q[4] & ~s3_q[4];
  wire osc_e    = s2_q[5] & ~s3_q[5];
  wire wake_e   = s2_q[6] & ~s3_q[6];
  wire sleep_s  = s2_q[7];
  wire por_e    = rise_s & ~s3_q[1];
  wire wdt_e    = wdt_s & ~s3_q[3];

  // master clear glitch filter: level must persist to be accepted
  // a pulse shorter than the filter length never reaches the sequencer
  logic [FW-1:0] filt_q;
  logic          master_clear_n_f_q;
  wire           filt_diff = master_clear_n_s != master_clear_n_f_q;
  wire           filt_done = filt_q == FW'(FILT_LEN - 1);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      filt_q   <= '0;
      master_clear_n_f_q <= 1'b1;
    end
    else
    begin
      filt_q   <= (filt_diff && !filt_done) ? filt_q + 1'b1 : '0;
      master_clear_n_f_q <= (filt_diff && filt_done) ? master_clear_n_s : master_clear_n_f_q;
    end
  end
  wire master_clear_n_fall = master_clear_n_f_q && filt_diff && filt_done;

  // configuration and flags
  logic [7:0] cfg_q;
  logic       bor_flag_q, por_flag_q, to_q, pd_q;
  rts_pkg::rts_cause_t cause_q;
  wire [1:0] osc_mode  = cfg_q[`RTS_CFG_OSC_LSB +: 2];
  wire       is_rc     = osc_mode == 2'(rts_pkg::RTS_OSC_RC);
  wire       bor_en    = cfg_q[`RTS_CFG_BOREN_BIT];
  wire       power_up_timer_on   = !cfg_q[`RTS_CFG_POWER_UP_TIMER_BIT] || bor_en;
  wire       bod_act   = bor_en && bod_s;

  // sequencer state
  // counters clear whenever their state is left, so a restart is full
  rts_state_t st_q;
  logic [PW-1:0] pw_q;
  logic [OW-1:0] ow_q;
  logic          ost_req_q;
  wire pw_done = pw_q == PW'(POWER_UP_TIMER_COUNT - 1);
  wire ow_done = ow_q == OW'(OST_COUNT - 1);
  wire wdt_rst = wdt_e && !sleep_s;
  wire master_clear_n_rst = master_clear_n_fall;
  wire any_start = por_e || bod_act || wdt_rst || master_clear_n_rst;
  wire use_ost_por = !is_rc;

  // cause and next state decode
  wire rts_pkg::rts_cause_t cause_d =
    por_e    ? rts_pkg::RTS_CAUSE_POR :
    bod_act  ? rts_pkg::RTS_CAUSE_BOR :
    master_clear_n_rst ? (sleep_s ? rts_pkg::RTS_CAUSE_MASTER_CLEAR_N_SLEEP
                        : rts_pkg::RTS_CAUSE_MASTER_CLEAR_N_RUN) :
    wdt_rst  ? rts_pkg::RTS_CAUSE_WDT : cause_q;
  wire after_pw_ost = ost_req_q;
  rts_state_t st_d;
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (por_e)
          st_d = power_up_timer_on ? ST_POWER_UP_TIMER : (use_ost_por ? ST_OST : ST_HOLD);
        else if (bod_act)
          st_d = ST_BROWN;
        else if (wdt_rst || master_clear_n_rst)
          st_d = ST_HOLD;
        else if (wake_e && sleep_s && !is_rc)
          st_d = ST_OST;
      ST_BROWN:
        if (!bod_act)
          st_d = ST_POWER_UP_TIMER;
      ST_POWER_UP_TIMER:
        if (bod_act)
          st_d = ST_BROWN;
        else if (pw_done && rcclk_e)
          st_d = after_pw_ost ? ST_OST : ST_HOLD;
      ST_OST:
        if (bod_act)
          st_d = ST_BROWN;
        else if (ow_done && osc_e)
          st_d = ST_HOLD;
      ST_HOLD:
        if (bod_act)
          st_d = ST_BROWN;
        else if (master_clear_n_f_q)
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  // timer counters on sampled rc and oscillator edges
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q      <= ST_IDLE;
      pw_q      <= '0;
      ow_q      <= '0;
      ost_req_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      pw_q <= (st_q != ST_POWER_UP_TIMER || st_d != ST_POWER_UP_TIMER) ? '0 :
              (rcclk_e ? pw_q + 1'b1 : pw_q);
      ow_q <= (st_q != ST_OST || st_d != ST_OST) ? '0 :
              (osc_e ? ow_q + 1'b1 : ow_q);
      if (por_e || bod_act)
        ost_req_q <= !is_rc;
    end
  end

  // reset output, clock divider, flags
  logic [1:0] div_q;
  wire  rst_d = (st_d != ST_IDLE) || !master_clear_n_f_q || any_start;
  wire  wr_pcs = bus.wr && bus.addr == `RTS_ADDR_PCS;
  wire  wr_cfg = bus.wr && bus.addr == `RTS_ADDR_CFG;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset    <= 1'b1;
      clock_out_pin <= 1'b0;
      div_q         <= 2'h0;
      keep_reg_wipe <= 1'b0;
      cfg_q         <= `RTS_CFG_RESET;
      bor_flag_q    <= 1'b0;
      por_flag_q    <= 1'b0;
      to_q          <= 1'b1;
      pd_q          <= 1'b1;
      cause_q       <= rts_pkg::RTS_CAUSE_NONE;
    end
    else
    begin
      core_reset    <= rst_d;
      div_q         <= osc_e ? div_q + 2'h1 : div_q;
      clock_out_pin <= is_rc && div_q[1];
      keep_reg_wipe <= por_e;
      cause_q       <= cause_d;
      if (wr_cfg)
        cfg_q <= bus.wdata;
      // hardware clears win over software sets
      if (bod_act)
        bor_flag_q <= 1'b0;
      else if (wr_pcs)
        bor_flag_q <= bus.wdata[`RTS_PCS_BOR_BIT];
      if (por_e)
        por_flag_q <= 1'b0;
      else if (wr_pcs)
        por_flag_q <= bus.wdata[`RTS_PCS_POR_BIT];
      if (por_e)
      begin
        to_q <= 1'b1;
        pd_q <= 1'b1;
      end
      else if (wdt_rst)
      begin
        to_q <= 1'b0;
        pd_q <= 1'b1;
      end
      else if (master_clear_n_rst && sleep_s)
      begin
        to_q <= 1'b1;
        pd_q <= 1'b0;
      end
    end
  end

  // read mux, data in cycle after the strobe
  wire [7:0] stat_w = {5'h00, core_reset, pd_q, to_q};
  wire [7:0] rmux =
    bus.addr == `RTS_ADDR_PCS   ? {6'h00, por_flag_q, bor_flag_q} :
    bus.addr == `RTS_ADDR_CFG   ? cfg_q :
    bus.addr == `RTS_ADDR_STAT  ? stat_w :
    bus.addr == `RTS_ADDR_CAUSE ? {5'h00, cause_q} : 8'h00;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata           <= 8'h00;
      master_clear_oe <= 1'b0;
    end
    else
    begin
      rdata           <= bus.rd ? rmux : 8'h00;
      master_clear_oe <= 1'b0;
    end
  end

  // checks
  a_pin_never_driven: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !master_clear_oe) else $error("master clear driven");
  a_master_clear_n_holds_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !master_clear_n_f_q |=> core_reset) else $error("reset not held");
  a_por_sets_to: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_e |=> to_q && pd_q) else $error("to/pd not set");
  a_por_clears_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_e |=> !por_flag_q) else $error("por flag kept");
  a_bor_clears_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bod_act |=> !bor_flag_q) else $error("bor flag kept");
  a_brown_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bod_act |=> ##1 core_reset) else $error("brown-out released");
  a_bor_forces_power_up_timer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bor_en |-> power_up_timer_on) else $error("power_up_timer not forced");
  a_power_up_timer_resets_cnt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == ST_BROWN) |=> pw_q == '0) else $error("power_up_timer not restarted");
  a_rc_no_ost: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_q == ST_POWER_UP_TIMER && st_d != ST_POWER_UP_TIMER && !bod_act && !ost_req_q)
    |=> st_q == ST_HOLD) else $error("ost in rc mode");
  a_clkout_rc_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(is_rc) |-> !clock_out_pin) else $error("clock out outside rc");
  // sequencing, flag and count checks
  a_timer_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q != ST_IDLE |-> core_reset)
    else $error("reset dropped early");
  a_wipe_on_por: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_e |=> keep_reg_wipe) else $error("no wipe on power-on");
  a_glitch_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !filt_done |=> $stable(master_clear_n_f_q)) else $error("glitch passed");
  a_brown_to_power_up_timer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_BROWN && !bod_act |=> st_q == ST_POWER_UP_TIMER)
    else $error("no delay after brown-out");
  a_late_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_HOLD && master_clear_n_f_q && !bod_act |=> st_q == ST_IDLE)
    else $error("late release delayed");
  a_wdt_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdt_rst && !por_e |=> !to_q && pd_q)
    else $error("watchdog flags wrong");
  a_sleep_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    master_clear_n_rst && sleep_s && !por_e && !wdt_rst |=> to_q && !pd_q)
    else $error("sleep clear flags wrong");
  a_ost_xtal_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_OST |-> !is_rc) else $error("start-up count in rc");
  a_cause_por: assert property (@(posedge clk_sys) disable iff (!rst_n)
    por_e |=> cause_q == rts_pkg::RTS_CAUSE_POR)
    else $error("power-on cause lost");
  a_power_up_timer_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_POWER_UP_TIMER |-> pw_q < PW'(POWER_UP_TIMER_COUNT))
    else $error("delay counter overrun");
  a_ost_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_OST |-> ow_q < OW'(OST_COUNT))
    else $error("start-up counter overrun");
  c_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_IDLE ##1 st_q == ST_OST);
  c_por: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_POWER_UP_TIMER ##1 st_q == ST_OST);
  c_brown: cover property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_BROWN ##1 st_q == ST_POWER_UP_TIMER);
  c_release: cover property (@(posedge clk_sys) disable iff (!rst_n)
    core_reset ##1 !core_reset);
endmodule
